/* File: include/ampp_defines.svh */
`ifndef AMPP_DEFINES_SVH
`define AMPP_DEFINES_SVH

`define AMPP_ADDR_W 24
`define AMPP_DATA_W 8
`define AMPP_BANK_LSB 22
`define AMPP_SETUP_CYCLES 2'h1
`define AMPP_SETUP_ZERO 2'h0
`define AMPP_ADDR_RST 24'h00_0000
`define AMPP_DATA_RST 8'h00
`define AMPP_BANKS_RST 4'hF
`define AMPP_BANKSEL_DEDICATED 2'h0
`define AMPP_BANKSEL_FLAG2 2'h2
`define AMPP_BANKSEL_FLAG3 2'h3
`define AMPP_SYNC_RST 2'h3
`define AMPP_STROBE_MIN 2'h2
`define AMPP_STROBE_ZERO 2'h0
`define AMPP_GFLAG_RST 4'hF

`endif

/* File: include/ampp_pkg.sv */
package ampp_pkg;

	// Function of the eight data pins
	typedef enum logic [1:0] {
		AMPP_DMODE_MEM = 2'h0,
		AMPP_DMODE_ACQ = 2'h1,
		AMPP_DMODE_FLAG = 2'h2,
		AMPP_DMODE_PWM = 2'h3
	} ampp_dmode_t;

	// Function of general flag pin 2
	typedef enum logic [1:0] {
		AMPP_F2_FLAG = 2'h0,
		AMPP_F2_IRQ = 2'h1,
		AMPP_F2_BANK = 2'h2
	} ampp_f2mode_t;

	// Function of general flag pin 3
	typedef enum logic [1:0] {
		AMPP_F3_FLAG = 2'h0,
		AMPP_F3_TIMER = 2'h1,
		AMPP_F3_BANK = 2'h2
	} ampp_f3mode_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0] wdata;
		logic write;
		logic cond;
	} ampp_req_t;

	typedef struct packed {
		ampp_dmode_t dmode;
		ampp_f2mode_t f2mode;
		ampp_f3mode_t f3mode;
		logic acq_on_addr;
	} ampp_cfg_t;

	typedef enum logic [3:0] {
		AMPP_IDLE = 4'b0001,
		AMPP_SETUP = 4'b0010,
		AMPP_STROBE = 4'b0100,
		AMPP_DONE = 4'b1000
	} ampp_state_t;

endpackage

/* File: hdl/ampp_port.sv */
// Notes on behaviour
// - Every external access shows its address on the 24-bit address bus.
// - After reset address/data pins serve memory; flag pins 0-3 are flags.
// - Data pins select memory data, acquisition input, flag I/O or PWM out.
// - When configured, acquisition channel 0 samples the address pins.
// - Low acknowledge holds off completion of the current external access.
// - Bank selects drive low as chip selects; two dedicated lines.
// - Bank selects are decoded address lines, changing with the address.
// - Selects idle without access; conditional accesses assert them even if false.
// - Read strobe asserts for every word read.
// - Write strobe asserts for every word written.
// - Flag pin 2 serves as flag, interrupt request 2 or bank select 2.
// - Flag pin 3 serves as flag, timer expiry output or bank select 3.
`timescale 1ns/1ns
`default_nettype none
`include "ampp_defines.svh"

module ampp_port
	import ampp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Core access request
	input wire logic req_valid,
	output logic req_ready,
	input wire ampp_req_t req,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	// Pin configuration
	input wire ampp_cfg_t cfg,
	// Core-side alternate functions
	input wire logic [7:0] flag_out,
	input wire logic [7:0] flag_oe,
	input wire logic [7:0] pwm_out,
	input wire logic [3:0] gflag_out,
	input wire logic [3:0] gflag_oe,
	input wire logic timer_expired,
	output logic [3:0] gflag_in,
	output logic irq2_req,
	output logic [7:0] data_in_sync,
	output logic [23:0] acq_data,
	output logic acq_valid,
	// Address pins
	output logic [23:0] ext_addr_bus_o,
	output logic ext_addr_bus_oe,
	input wire logic [23:0] ext_addr_bus_i,
	// Data pins
	output logic [7:0] ext_data_bus_o,
	output logic [7:0] ext_data_bus_oe,
	input wire logic [7:0] ext_data_bus_i,
	// Strobes, selects and acknowledge
	input wire logic ext_wait_ack,
	output logic [1:0] bank_select_n,
	output logic ext_read_strobe_n,
	output logic ext_write_strobe_n,
	// General flag pins 0 to 3
	output logic [3:0] gflag_pin_o,
	output logic [3:0] gflag_pin_oe,
	input wire logic [3:0] gflag_pin_i
);

	ampp_state_t state_ff, nxt_state;
	ampp_req_t cur_ff;
	logic [1:0] setup_ff;
	logic [3:0] banks_n_ff;
	logic [23:0] addr_ff;
	logic ack_meta_ff, ack_sync_ff;
	logic [7:0] data_meta_ff, data_sync_ff;
	logic [23:0] abus_meta_ff, abus_sync_ff;
	logic [3:0] gf_meta_ff, gf_sync_ff;
	logic [7:0] rdata_ff;
	logic rd_n_ff, wr_n_ff;
	logic data_drive_ff;
	logic acq_valid_ff;
	logic [1:0] strobe_cnt_ff;
	logic take;

	// Top two address bits pick one of four banks, active low
	function automatic logic [3:0] bank_decode(input logic [23:0] a);
		logic [3:0] d;
		d = `AMPP_BANKS_RST;
		d[a[`AMPP_BANK_LSB +: 2]] = 1'b0;
		return d;
	endfunction

	// Two-stage synchronisers for every pin that is read
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack_meta_ff <= 1'b1;
			ack_sync_ff <= 1'b1;
		end else begin
			ack_meta_ff <= ext_wait_ack;
			ack_sync_ff <= ack_meta_ff;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			data_meta_ff <= `AMPP_DATA_RST;
			data_sync_ff <= `AMPP_DATA_RST;
			abus_meta_ff <= `AMPP_ADDR_RST;
			abus_sync_ff <= `AMPP_ADDR_RST;
			// Pull-ups idle the flag pins high; a low reset value would fake an interrupt
			gf_meta_ff <= `AMPP_GFLAG_RST;
			gf_sync_ff <= `AMPP_GFLAG_RST;
		end else begin
			data_meta_ff <= ext_data_bus_i;
			data_sync_ff <= data_meta_ff;
			abus_meta_ff <= ext_addr_bus_i;
			abus_sync_ff <= abus_meta_ff;
			gf_meta_ff <= gflag_pin_i;
			gf_sync_ff <= gf_meta_ff;
		end
	end

	// Access sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			AMPP_IDLE: begin
				if (take) begin
					nxt_state = AMPP_SETUP;
				end
			end
			AMPP_SETUP: begin
				if (setup_ff == `AMPP_SETUP_ZERO) begin
					nxt_state = AMPP_STROBE;
				end
			end
			AMPP_STROBE: begin
				// A held-low acknowledge stretches the strobe indefinitely
				// The minimum length lets the data pins pass their synchroniser under it
				if (ack_sync_ff && strobe_cnt_ff == `AMPP_STROBE_ZERO) begin
					nxt_state = AMPP_DONE;
				end
			end
			AMPP_DONE: begin
				nxt_state = AMPP_IDLE;
			end
			default: begin
				nxt_state = AMPP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_ff <= AMPP_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cur_ff <= '0;
			setup_ff <= `AMPP_SETUP_ZERO;
		end else if (take) begin
			cur_ff <= req;
			setup_ff <= `AMPP_SETUP_CYCLES;
		end else if (state_ff == AMPP_SETUP && setup_ff != `AMPP_SETUP_ZERO) begin
			setup_ff <= setup_ff - 2'h1;
		end
	end

	// Address and selects load together so they change in one cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			addr_ff <= `AMPP_ADDR_RST;
			banks_n_ff <= `AMPP_BANKS_RST;
		end else if (take) begin
			addr_ff <= req.addr;
			// Conditional accesses still select, whatever their outcome
			banks_n_ff <= bank_decode(req.addr);
		end else if (state_ff == AMPP_DONE) begin
			banks_n_ff <= `AMPP_BANKS_RST;
		end
	end

	// Strobes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rd_n_ff <= 1'b1;
			wr_n_ff <= 1'b1;
		end else if (nxt_state == AMPP_STROBE) begin
			// A false conditional access selects the bank but pulses no strobe
			rd_n_ff <= !(!cur_ff.write && cur_ff.cond);
			wr_n_ff <= !(cur_ff.write && cur_ff.cond);
		end else begin
			rd_n_ff <= 1'b1;
			wr_n_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			data_drive_ff <= 1'b0;
		end else begin
			// Drive starts in setup so the last access's write flag never leaks out
			data_drive_ff <= (state_ff == AMPP_SETUP || nxt_state == AMPP_STROBE)
				&& cur_ff.write && cur_ff.cond;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= `AMPP_DATA_RST;
		end else if (state_ff == AMPP_STROBE && nxt_state == AMPP_DONE && !rd_n_ff) begin
			// Ack and data share one synchroniser depth, so this is the acknowledged byte
			rdata_ff <= data_sync_ff;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			strobe_cnt_ff <= `AMPP_STROBE_ZERO;
		end else if (state_ff != AMPP_STROBE && nxt_state == AMPP_STROBE) begin
			strobe_cnt_ff <= `AMPP_STROBE_MIN;
		end else if (state_ff == AMPP_STROBE && strobe_cnt_ff != `AMPP_STROBE_ZERO) begin
			strobe_cnt_ff <= strobe_cnt_ff - 2'h1;
		end
	end

	// Parallel acquisition from the address pins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			acq_valid_ff <= 1'b0;
		end else begin
			acq_valid_ff <= cfg.acq_on_addr;
		end
	end

	// Acquisition owns the address pins, so no access may start meanwhile
	assign req_ready = (state_ff == AMPP_IDLE) && !cfg.acq_on_addr;
	assign take = req_ready && req_valid;
	assign rsp_valid = (state_ff == AMPP_DONE);
	assign rsp_rdata = rdata_ff;
	assign acq_data = abus_sync_ff;
	assign acq_valid = acq_valid_ff;
	assign data_in_sync = data_sync_ff;

	// Address pins turn round to inputs only in acquisition mode
	assign ext_addr_bus_o = addr_ff;
	assign ext_addr_bus_oe = !cfg.acq_on_addr;

	// Registered pins: alternate functions show one cycle after their inputs
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ext_data_bus_o <= `AMPP_DATA_RST;
			ext_data_bus_oe <= `AMPP_DATA_RST;
		end else begin
			unique case (cfg.dmode)
				AMPP_DMODE_MEM: begin
					ext_data_bus_o <= cur_ff.wdata;
					ext_data_bus_oe <= {8{data_drive_ff}};
				end
				AMPP_DMODE_ACQ: begin
					ext_data_bus_o <= `AMPP_DATA_RST;
					ext_data_bus_oe <= 8'h00;
				end
				AMPP_DMODE_FLAG: begin
					ext_data_bus_o <= flag_out;
					ext_data_bus_oe <= flag_oe;
				end
				AMPP_DMODE_PWM: begin
					ext_data_bus_o <= pwm_out;
					ext_data_bus_oe <= 8'hFF;
				end
			endcase
		end
	end

	assign bank_select_n = banks_n_ff[1:0];
	assign ext_read_strobe_n = rd_n_ff;
	assign ext_write_strobe_n = wr_n_ff;

	// Flag pins; configuration defaults give plain flags after reset
	assign gflag_in = gf_sync_ff;
	assign irq2_req = (cfg.f2mode == AMPP_F2_IRQ) && !gf_sync_ff[2];

	always_comb begin
		gflag_pin_o = gflag_out;
		gflag_pin_oe = gflag_oe;
		if (cfg.f2mode == AMPP_F2_IRQ) begin
			gflag_pin_oe[2] = 1'b0;
		end else if (cfg.f2mode == AMPP_F2_BANK) begin
			gflag_pin_o[2] = banks_n_ff[2];
			gflag_pin_oe[2] = 1'b1;
		end
		if (cfg.f3mode == AMPP_F3_TIMER) begin
			gflag_pin_o[3] = timer_expired;
			gflag_pin_oe[3] = 1'b1;
		end else if (cfg.f3mode == AMPP_F3_BANK) begin
			gflag_pin_o[3] = banks_n_ff[3];
			gflag_pin_oe[3] = 1'b1;
		end
	end

endmodule
`default_nettype wire

/* File: dv/ampp_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module ampp_chk
	import ampp_pkg::*;
(
	// Core side
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire ampp_req_t req,
	input wire ampp_cfg_t cfg,
	input wire logic rsp_valid,
	// Pins
	input wire logic ext_wait_ack,
	input wire logic [23:0] ext_addr_bus_o,
	input wire logic ext_addr_bus_oe,
	input wire logic [1:0] bank_select_n,
	input wire logic ext_read_strobe_n,
	input wire logic ext_write_strobe_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire logic tk = req_valid && req_ready;
	property p_addr; tk |=> ext_addr_bus_o == $past(req.addr); endproperty
	a_addr: assert property (p_addr) else $error("address wrong");
	property p_sel;
		tk && !req.addr[23] |=> bank_select_n == ~(2'b01 << $past(req.addr[22]));
	endproperty
	a_sel: assert property (p_sel) else $error("select wrong");
	property p_idle; req_ready |-> bank_select_n == 2'b11; endproperty
	a_idle: assert property (p_idle) else $error("select while idle");
	property p_cond; tk && !req.cond |=> (ext_read_strobe_n && ext_write_strobe_n) [*4]; endproperty
	a_cond: assert property (p_cond) else $error("strobe on false access");
	property p_rd; tk && req.cond && !req.write |-> ##[1:8] !ext_read_strobe_n; endproperty
	a_rd: assert property (p_rd) else $error("no read strobe");
	property p_wr; tk && req.cond && req.write |-> ##[1:8] !ext_write_strobe_n; endproperty
	a_wr: assert property (p_wr) else $error("no write strobe");
	// Three low samples leave the synchroniser low, so no completion may follow
	property p_ack; !ext_wait_ack [*3] |=> !rsp_valid; endproperty
	a_ack: assert property (p_ack) else $error("done while held off");
	property p_acq;
		cfg.acq_on_addr |-> (!req_ready && !ext_addr_bus_oe) ##1 $stable(ext_addr_bus_o);
	endproperty
	a_acq: assert property (p_acq) else $error("address pins driven");
	c_wait: cover property (!ext_wait_ack && !ext_read_strobe_n);
	c_wr: cover property (!ext_write_strobe_n);
	c_acq: cover property (cfg.acq_on_addr);
endmodule
bind ampp_port ampp_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid),
	.req_ready(req_ready), .req(req), .cfg(cfg), .rsp_valid(rsp_valid),
	.ext_wait_ack(ext_wait_ack), .ext_addr_bus_o(ext_addr_bus_o), .ext_addr_bus_oe(ext_addr_bus_oe),
	.bank_select_n(bank_select_n), .ext_read_strobe_n(ext_read_strobe_n),
	.ext_write_strobe_n(ext_write_strobe_n));
`default_nettype wire

/* File: dv/ampp_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module ampp_mem (
	// Device pins
	input wire logic clk_sys,
	input wire logic [23:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [1:0] sel_n,
	input wire logic rd_n,
	input wire logic wr_n,
	// Wait states per access
	input wire logic [3:0] waits,
	output logic ack,
	output logic [7:0] rdata
);
	logic [7:0] mem_ff [256];
	logic [3:0] cnt_ff = 4'h0;
	logic sel_ff = 1'b0;
	always_ff @(posedge clk_sys) begin
		sel_ff <= ~&sel_n;
		if (~&sel_n && !sel_ff) begin
			cnt_ff <= waits;
		end else if (cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
		if (!wr_n) begin
			mem_ff[addr[7:0]] <= wdata;
		end
	end
	assign ack = cnt_ff == 4'h0;
	// Released bus shows inverted data so a late capture cannot pass
	assign rdata = rd_n ? ~mem_ff[addr[7:0]] : mem_ff[addr[7:0]];
endmodule
`default_nettype wire

/* File: dv/async_memory_port_pins_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module async_memory_port_pins_tb_top;
	import ampp_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	ampp_req_t req = '0;
	ampp_cfg_t cfg = '0;
	logic [23:0] ai = 24'h12_3456;
	logic [7:0] alt = 8'h5A;
	logic [7:0] foe = 8'h0F;
	logic [3:0] waits = 4'h0;
	logic [3:0] gpi = 4'hF;
	logic tmr = 1'b0;
	logic rdy, rsp, ack, rd_n, wr_n, aoe, acqv, irq;
	logic [1:0] sel;
	logic [3:0] goe, gin, gpo;
	logic [7:0] rdat, dout, doe, din, mdat, dsync;
	logic [23:0] ao, acq;
	int num_errors = 0;
	int total_checks = 0;
	int lat;
	always #50 clk_sys = ~clk_sys;
	// Data wire resolved from the device's enables
	assign din = (doe & dout) | (~doe & mdat);
	ampp_port uut (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req_ready(rdy),
		.req(req), .rsp_valid(rsp), .rsp_rdata(rdat), .cfg(cfg), .flag_out(alt), .flag_oe(foe),
		.pwm_out(alt), .gflag_out(4'h0), .gflag_oe(4'h0), .timer_expired(tmr), .gflag_in(gin),
		.irq2_req(irq), .data_in_sync(dsync), .acq_data(acq), .acq_valid(acqv),
		.ext_addr_bus_o(ao),
		.ext_addr_bus_oe(aoe), .ext_addr_bus_i(ai), .ext_data_bus_o(dout), .ext_data_bus_oe(doe),
		.ext_data_bus_i(din), .ext_wait_ack(ack), .bank_select_n(sel), .ext_read_strobe_n(rd_n),
		.ext_write_strobe_n(wr_n), .gflag_pin_o(gpo), .gflag_pin_oe(goe), .gflag_pin_i(gpi));
	ampp_mem mem (.clk_sys(clk_sys), .addr(ao), .wdata(din), .sel_n(sel), .rd_n(rd_n),
		.wr_n(wr_n), .waits(waits), .ack(ack), .rdata(mdat));
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic acc(input logic wr, input logic cnd, input logic [23:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= {a, d, wr, cnd};
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(negedge clk_sys);
		chk("addr", a, ao);
		if (!a[23]) begin
			chk("sel", {22'h0, ~(2'b01 << a[22])}, {22'h0, sel});
		end
		for (lat = 1; lat < 40 && rsp !== 1'b1; lat++) begin
			@(negedge clk_sys);
		end
		if (rsp !== 1'b1) begin
			chk("rsp", 24'h00_0001, {23'h0, rsp});
			final_report();
		end
	endtask
	task automatic t_reset;
		@(negedge clk_sys);
		chk("addr_oe", 24'h00_0001, {23'h0, aoe});
		chk("data_oe", 24'h00_0000, {16'h0, doe});
		chk("flag_oe", 24'h00_0000, {20'h0, goe});
		chk("sel_rst", 24'h00_0003, {22'h0, sel});
		chk("strobes_rst", 24'h00_0003, {22'h0, rd_n, wr_n});
		$display("reset done");
	endtask
	task automatic t_rw;
		acc(1'b1, 1'b1, 24'h40_0123, 8'hA5);
		acc(1'b1, 1'b1, 24'h00_0124, 8'h3C);
		acc(1'b0, 1'b1, 24'h40_0123, 8'h00);
		chk("rdata", 24'h00_00A5, {16'h0, rdat});
		acc(1'b0, 1'b1, 24'h00_0124, 8'h00);
		chk("rdata", 24'h00_003C, {16'h0, rdat});
		$display("rw done");
	endtask
	task automatic t_wait;
		@(posedge clk_sys);
		waits <= 4'h9;
		acc(1'b1, 1'b0, 24'h40_0123, 8'h77);
		acc(1'b0, 1'b1, 24'h40_0123, 8'h00);
		chk("slow", 24'h00_0001, {23'h0, lat >= 13});
		chk("rdata", 24'h00_00A5, {16'h0, rdat});
		waits <= 4'h0;
		$display("wait done");
	endtask
	task automatic t_mode;
		@(posedge clk_sys);
		cfg.dmode <= AMPP_DMODE_PWM;
		repeat (2) @(negedge clk_sys);
		chk("pwm", {16'h0, alt}, {16'h0, dout & doe});
		chk("pwm_oe", 24'h00_00FF, {16'h0, doe});
		@(posedge clk_sys);
		cfg.dmode <= AMPP_DMODE_FLAG;
		repeat (2) @(negedge clk_sys);
		chk("flag_oe", {16'h0, foe}, {16'h0, doe});
		@(posedge clk_sys);
		cfg.dmode <= AMPP_DMODE_ACQ;
		repeat (4) @(negedge clk_sys);
		chk("acq_oe", 24'h00_0000, {16'h0, doe});
		chk("acq_pins", 24'h00_005A, {16'h0, dsync});
		@(posedge clk_sys);
		cfg.dmode <= AMPP_DMODE_MEM;
		cfg.acq_on_addr <= 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("acq", ai, acq);
		chk("acq_valid", 24'h00_0001, {23'h0, acqv});
		chk("ready", 24'h00_0000, {23'h0, rdy});
		chk("addr_oe", 24'h00_0000, {23'h0, aoe});
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= {24'h00_0055, 8'h00, 1'b0, 1'b1};
		repeat (3) @(posedge clk_sys);
		req_valid <= 1'b0;
		cfg.acq_on_addr <= 1'b0;
		@(negedge clk_sys);
		chk("acq_hold", 24'h40_0123, ao);
		$display("mode done");
	endtask
	task automatic t_flag;
		@(posedge clk_sys);
		cfg.f2mode <= AMPP_F2_BANK;
		cfg.f3mode <= AMPP_F3_TIMER;
		tmr <= 1'b1;
		@(negedge clk_sys);
		chk("gflag_oe", 24'h00_000C, {20'h0, goe});
		chk("gflag_pins", 24'h00_000C, {20'h0, gpo});
		acc(1'b1, 1'b1, 24'h80_0010, 8'h11);
		chk("bank2", 24'h00_0008, {20'h0, gpo});
		chk("sel_idle", 24'h00_0003, {22'h0, sel});
		@(posedge clk_sys);
		cfg.f2mode <= AMPP_F2_IRQ;
		gpi <= 4'hB;
		repeat (3) @(negedge clk_sys);
		chk("irq2", 24'h00_0001, {23'h0, irq});
		chk("gflag_in", 24'h00_000B, {20'h0, gin});
		@(posedge clk_sys);
		cfg <= '0;
		gpi <= 4'hF;
		tmr <= 1'b0;
		$display("flag done");
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_rw();
		t_wait();
		t_mode();
		t_flag();
		final_report();
	end
endmodule
`default_nettype wire
